// ==== pkg/aof_pkg.sv ====
// Package of constants and carrier types for the converter output formatter.
package aof_pkg;

   localparam int unsigned SampleWidth = 14;
   localparam int unsigned MsbPos      = 13;
   localparam int unsigned LfsrWidth   = 23;

   // Mode pin levels after quantisation by the front end.
   localparam logic [1:0] ModeGround    = 2'h0;
   localparam logic [1:0] ModeOneThird  = 2'h1;
   localparam logic [1:0] ModeTwoThirds = 2'h2;
   localparam logic [1:0] ModeFull      = 2'h3;

   // Register offsets of the control port.
   localparam logic [3:0] RegCtrl   = 4'h0;
   localparam logic [3:0] RegStatus = 4'h1;
   localparam logic [3:0] RegMask   = 4'h2;
   localparam logic [3:0] RegSample = 4'h3;

   // Control register field positions.
   localparam int unsigned CtrlScramblePos = 0;
   localparam int unsigned CtrlDitherPos   = 1;

   // Status and mask bit positions.
   localparam int unsigned StatRangePos  = 0;
   localparam int unsigned StatSamplePos = 1;
   localparam int unsigned StatWidth     = 2;

   // Reset values.
   localparam logic [LfsrWidth-1:0] LfsrSeed = 23'h000001;
   localparam logic [1:0]           CtrlReset = 2'h0;
   localparam logic [StatWidth-1:0] MaskReset = 2'h0;

   // Carrier of one formatted sample.
   typedef struct packed {
      logic                   rangeExceeded;
      logic [SampleWidth-1:0] data;
   } aof_sample_s;

   // Decoded mode pin.
   typedef struct packed {
      logic twosComplement;
      logic stabilizerOn;
   } aof_mode_s;

endpackage

// ==== verification/aof_capture_model.sv ====
// Capture latch model that sits on the formatter's parallel sample outputs.
`timescale 1ns/100ps
module aof_capture_model
   import aof_pkg::*;
(
   input  wire logic                   clockTrue,
   input  wire logic                   descramble,
   input  wire logic [SampleWidth-1:0] sampleData,
   input  wire logic                   rangeFlag,
   output aof_sample_s                 captured,
   output logic      [SampleWidth-1:0] plainData
);
   // Latch on the true clock rise, half a period after the word changed.
   always @(posedge clockTrue)
   begin
      captured <= '{rangeExceeded: rangeFlag, data: sampleData};
   end

   // Undo scrambling with the received LSB; the LSB itself is sent plain.
   always_comb
   begin
      plainData = captured.data;
      if (descramble)
         plainData[MsbPos:1] = captured.data[MsbPos:1]
            ^ {MsbPos{captured.data[0]}};
   end
endmodule

// ==== verification/test_adc_output_formatter.sv ====
// Self-checking bench for the converter output formatter.
`timescale 1ns/100ps
module test_adc_output_formatter
   import aof_pkg::*;
   ;
   logic                   clk = 0, rst_n = 0, encodeClock = 0;
   logic                   scrambleEnable = 0, ditherEnable = 0;
   logic                   coreOverRange = 0, regWrite = 0, regRead = 0;
   logic [1:0]             modeLevel = 0;
   logic [SampleWidth-1:0] coreSample = '0, capPlain, sampleData, diff;
   logic [3:0]             regAddr = 0;
   logic [31:0]            regWdata = 0, regRdata, rd;
   logic                   rangeFlag, clkTrue, clkInv, stabOn, irq;
   logic                   scrOn = 0, anyDither = 0;
   aof_sample_s            capWord;
   int                     n_errors = 0, tests_run = 0, cycles = 0;

   // 125 MHz system clock.
   always #4 clk = ~clk;

   adc_output_formatter u_adc_output_formatter (
      .clk(clk), .rst_n(rst_n), .encodeClock(encodeClock),
      .modeLevel(modeLevel), .scrambleEnable(scrambleEnable),
      .ditherEnable(ditherEnable), .coreSample(coreSample),
      .coreOverRange(coreOverRange), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .sampleData(sampleData),
      .range_exceeded_flag(rangeFlag), .sample_clock_out_true(clkTrue),
      .sample_clock_out_inverted(clkInv), .stabilizerEnable(stabOn),
      .irq(irq));

   aof_capture_model u_aof_capture_model (
      .clockTrue(clkTrue), .descramble(scrOn), .sampleData(sampleData),
      .rangeFlag(rangeFlag), .captured(capWord), .plainData(capPlain));

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // A hung handshake would stall the run, so cycles are capped.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic regWr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic regRd(input logic [3:0] a, input logic [31:0] exp,
                        input string what);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 check(what, exp, regRdata);
   endtask

   // Expected word: MSB flip for two's complement, then scrambling.
   function automatic logic [SampleWidth-1:0] fmt(
      input logic [SampleWidth-1:0] r, input logic tc, input logic sc);
      logic [SampleWidth-1:0] w;
      w = r;
      w[MsbPos] = w[MsbPos] ^ tc;
      if (sc)
         w[MsbPos:1] = w[MsbPos:1] ^ {MsbPos{w[0]}};
      return w;
   endfunction

   // One 160 ns encode period; checks the word as the true clock falls.
   task automatic sample(input logic [SampleWidth-1:0] raw,
                         input logic ovr, input logic tc, input logic sc);
      int  k;
      real t0;
      @(posedge clk);
      coreSample    <= raw;
      coreOverRange <= ovr;
      #3 encodeClock = 1'b1;
      t0 = $realtime;
      k = 0;
      while (clkTrue !== 1'b0 && k < 12)
      begin
         @(posedge clk);
         #1 k++;
      end
      check("inverted clock", 32'h1, 32'(clkInv));
      check("data", 32'(fmt(raw, tc, sc)), 32'(sampleData));
      check("range flag", 32'(ovr), 32'(rangeFlag));
      #(t0 + 80.0 - $realtime) encodeClock = 1'b0;
      #80 check("true clock", 32'h2, 32'({clkTrue, clkInv}));
      check("captured", 32'(fmt(raw, tc, 1'b0)), 32'(capPlain));
      check("captured flag", 32'(ovr), 32'(capWord.rangeExceeded));
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      check("reset outputs", 32'h2, 32'({sampleData, clkTrue, clkInv}));
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      regRd(RegCtrl, 32'(CtrlReset), "ctrl reset");
      regRd(RegMask, 32'(MaskReset), "mask reset");
      regWr(4'h9, 32'h3);
      regRd(4'h9, 32'h0, "unmapped");
      // Every mode level, plain and scrambled, the full-scale word 3fff included.
      for (int i = 0; i < 8; i++)
      begin
         modeLevel      <= 2'(i >> 1);
         scrambleEnable <= i[0];
         scrOn          <= i[0];
         repeat (4) @(posedge clk);
         check("stabilizer", 32'(i[2] ^ i[1]), 32'(stabOn));
         sample(14'h3fff - 14'(i * 14'h0923), i[0] & i[1], i[2],
                i[0]);
      end
      modeLevel      <= 2'h0;
      scrambleEnable <= 1'b0;
      scrOn          <= 1'b0;
      repeat (4) @(posedge clk);
      // Interrupt: both events pending, then masked, cleared and masked off.
      regRd(RegStatus, 32'h3, "status");
      regWr(RegMask, 32'h2);
      repeat (2) @(posedge clk);
      #1 check("irq on", 32'h1, 32'(irq));
      regWr(RegStatus, 32'h3);
      repeat (2) @(posedge clk);
      #1 check("irq cleared", 32'h0, 32'(irq));
      regRd(RegStatus, 32'h0, "status cleared");
      sample(14'h1234, 1'b0, 1'b0, 1'b0);
      regRd(RegSample, 32'h00001234, "last sample");
      #1 check("irq sample", 32'h1, 32'(irq));
      regWr(RegMask, 32'h0);
      repeat (2) @(posedge clk);
      #1 check("irq masked", 32'h0, 32'(irq));
      // Scrambling requested through the control register instead of the pin.
      regWr(RegCtrl, 32'h1);
      regRd(RegCtrl, 32'h1, "ctrl");
      scrOn <= 1'b1;
      sample(14'h2a5d, 1'b1, 1'b0, 1'b1);
      regWr(RegCtrl, 32'h0);
      scrOn <= 1'b0;
      // Dither: result sits below raw by a small pseudo-random amount.
      ditherEnable <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         coreSample <= 14'h2000;
         #3 encodeClock = 1'b1;
         #80 encodeClock = 1'b0;
         #77 diff = 14'h2000 - sampleData;
         check("dither bound", 32'h1, 32'(diff <= 14'h7f));
         anyDither |= (diff != 0);
      end
      check("dither seen", 32'h1, 32'(anyDither));
      ditherEnable <= 1'b0;
      repeat (4) @(posedge clk);
      sample(14'h2000, 1'b0, 1'b0, 1'b0);
      test_done();
   end
endmodule

// ==== verilog/adc_output_formatter.sv ====
// Output formatter: coding, range flag, scrambling, dither and output clocks.
`timescale 1ns/100ps

// Summary of operation
// - Mode level 0 OB/off, 1 OB/on, 2 TC/on, 3 TC/off (coding/stabilizer).
// - Each sample leaves as a parallel word, offset binary or two's compl.
// - Range flag is high exactly when the sample was over or under range.
// - A delayed encode clock leaves as a true and an inverted output.
// - Data change as the true clock falls and the inverted clock rises.
// - Scrambling XORs every non-LSB data bit with the LSB.
// - LSB, range flag and output clocks are untouched by scrambling.
// - Scrambling acts only while scramble enable or control bit 0 is high.
// - With dither on, a pseudo-random value per sample is subtracted.
// - Results carry fourteen bits per sample.
module adc_output_formatter
   import aof_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   encodeClock,
   input  wire logic [1:0]             modeLevel,
   input  wire logic                   scrambleEnable,
   input  wire logic                   ditherEnable,
   input  wire logic [SampleWidth-1:0] coreSample,
   input  wire logic                   coreOverRange,
   input  wire logic [3:0]             regAddr,
   input  wire logic [31:0]            regWdata,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   output logic      [31:0]            regRdata,
   output logic      [SampleWidth-1:0] sampleData,
   output logic                        range_exceeded_flag,
   output logic                        sample_clock_out_true,
   output logic                        sample_clock_out_inverted,
   output logic                        stabilizerEnable,
   output logic                        irq
);

   // Pin inputs from the encode domain pass two flip-flops first.
   logic [1:0] encSync_r;
   logic [1:0] encSync_nxt;
   logic       encPrev_r;
   logic [1:0] modeMeta_r;
   logic [1:0] modeSync_r;
   logic [1:0] scrMeta_r;
   logic [1:0] ditMeta_r;

   always_comb
   begin
      encSync_nxt = {encSync_r[0], encodeClock};
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         encSync_r  <= 2'h0;
         encPrev_r  <= 1'b0;
         modeMeta_r <= 2'h0;
         modeSync_r <= 2'h0;
         scrMeta_r  <= 2'h0;
         ditMeta_r  <= 2'h0;
      end
      else
      begin
         encSync_r  <= encSync_nxt;
         encPrev_r  <= encSync_r[1];
         modeMeta_r <= modeLevel;
         modeSync_r <= modeMeta_r;
         scrMeta_r  <= {scrMeta_r[0], scrambleEnable};
         ditMeta_r  <= {ditMeta_r[0], ditherEnable};
      end
   end

   logic encRise;
   logic scrOn;
   logic ditOn;
   assign encRise = encSync_r[1] & ~encPrev_r;

   // Decode the four-level mode input.
   function automatic aof_mode_s decodeMode(input logic [1:0] lvl);
      aof_mode_s m;
      m = '0;
      case (lvl)
         ModeGround:    m = '{twosComplement: 1'b0, stabilizerOn: 1'b0};
         ModeOneThird:  m = '{twosComplement: 1'b0, stabilizerOn: 1'b1};
         ModeTwoThirds: m = '{twosComplement: 1'b1, stabilizerOn: 1'b1};
         ModeFull:      m = '{twosComplement: 1'b1, stabilizerOn: 1'b0};
         default:       m = '0;
      endcase
      return m;
   endfunction

   aof_mode_s modeNow;
   assign modeNow = decodeMode(modeSync_r);

   // Software control bits are OR-ed with the pins so either may enable.
   logic [1:0] ctrl_r;
   logic [1:0] ctrl_nxt;
   assign scrOn = scrMeta_r[1] | ctrl_r[CtrlScramblePos];
   assign ditOn = ditMeta_r[1] | ctrl_r[CtrlDitherPos];

   logic [SampleWidth-1:0] ditherValue;

   aof_lfsr u_aof_lfsr
   (
      .clk     (clk),
      .rst_n   (rst_n),
      .advance (encRise & ditOn),
      .value   (ditherValue)
   );

   // Formatting of one sample: dither, coding, then scrambling.
   function automatic logic [SampleWidth-1:0] formatWord(
      input logic [SampleWidth-1:0] raw,
      input logic [SampleWidth-1:0] dith,
      input logic                   useDither,
      input logic                   twos,
      input logic                   scramble);
      logic [SampleWidth-1:0] w;
      w = raw;
      if (useDither)
      begin
         w = raw - dith;
      end
      if (twos)
      begin
         w[MsbPos] = ~w[MsbPos];
      end
      if (scramble)
      begin
         w[MsbPos:1] = w[MsbPos:1] ^ {(SampleWidth-1){w[0]}};
      end
      return w;
   endfunction

   // Output stage: data and clocks update on the synchronised encode edges.
   aof_sample_s outWord_r;
   aof_sample_s outWord_nxt;
   logic        clkTrue_r;
   logic        clkTrue_nxt;
   logic        stab_r;

   always_comb
   begin
      outWord_nxt = outWord_r;
      clkTrue_nxt = clkTrue_r;
      if (encRise)
      begin
         // Data change exactly as the true clock falls.
         outWord_nxt.data          = formatWord(coreSample, ditherValue,
                                        ditOn, modeNow.twosComplement,
                                        scrOn);
         outWord_nxt.rangeExceeded = coreOverRange;
         clkTrue_nxt               = 1'b0;
      end
      else if (!encSync_r[1] && encPrev_r)
      begin
         // Rising true clock marks stable data for the receiver.
         clkTrue_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         outWord_r <= '0;
         clkTrue_r <= 1'b1;
         stab_r    <= 1'b0;
      end
      else
      begin
         outWord_r <= outWord_nxt;
         clkTrue_r <= clkTrue_nxt;
         stab_r    <= modeNow.stabilizerOn;
      end
   end

   // Complementary pair comes from flops so both edges line up.
   logic clkInv_r;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clkInv_r <= 1'b0;
      end
      else
      begin
         clkInv_r <= ~clkTrue_nxt;
      end
   end

   assign sampleData                = outWord_r.data;
   assign range_exceeded_flag       = outWord_r.rangeExceeded;
   assign sample_clock_out_true     = clkTrue_r;
   assign sample_clock_out_inverted = clkInv_r;
   assign stabilizerEnable          = stab_r;

   // Register port: status sticky bits, mask, control and last sample.
   logic [StatWidth-1:0] status_r;
   logic [StatWidth-1:0] status_nxt;
   logic [StatWidth-1:0] mask_r;
   logic [StatWidth-1:0] mask_nxt;
   logic [31:0]          rdata_nxt;
   logic                 irq_nxt;
   logic [StatWidth-1:0] events;

   always_comb
   begin
      events                = '0;
      events[StatRangePos]  = encRise & coreOverRange;
      events[StatSamplePos] = encRise;
      ctrl_nxt   = ctrl_r;
      mask_nxt   = mask_r;
      status_nxt = status_r;
      if (regWrite && regAddr == RegCtrl)
      begin
         ctrl_nxt = regWdata[1:0];
      end
      if (regWrite && regAddr == RegMask)
      begin
         mask_nxt = regWdata[StatWidth-1:0];
      end
      if (regWrite && regAddr == RegStatus)
      begin
         status_nxt = status_nxt & ~regWdata[StatWidth-1:0];
      end
      // A new event wins over a clear in the same cycle.
      status_nxt = status_nxt | events;
      rdata_nxt  = 32'h0;
      if (regRead)
      begin
         case (regAddr)
            RegCtrl:   rdata_nxt = {30'h0, ctrl_r};
            RegStatus: rdata_nxt = {30'h0, status_r};
            RegMask:   rdata_nxt = {30'h0, mask_r};
            RegSample: rdata_nxt = {17'h0, outWord_r};
            default:   rdata_nxt = 32'h0;
         endcase
      end
      irq_nxt = |(status_nxt & mask_nxt);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r   <= CtrlReset;
         mask_r   <= MaskReset;
         status_r <= '0;
         regRdata <= 32'h0;
         irq      <= 1'b0;
      end
      else
      begin
         ctrl_r   <= ctrl_nxt;
         mask_r   <= mask_nxt;
         status_r <= status_nxt;
         regRdata <= rdata_nxt;
         irq      <= irq_nxt;
      end
   end

   // Checks on the output stage; all of them live in the system clock domain.
   default clocking aofCb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence encEdge_q;
      encRise;
   endsequence

   sequence clockFalls_q;
      !sample_clock_out_true && sample_clock_out_inverted;
   endsequence

   clock_pair_a : assert property (
      sample_clock_out_inverted == !sample_clock_out_true)
      else $error("Output clocks are not complementary.");

   data_edge_a : assert property (
      encEdge_q |=> clockFalls_q)
      else $error("Data update without true clock falling.");

   data_stable_a : assert property (
      !$fell(sample_clock_out_true) |-> $stable(sampleData))
      else $error("Data changed away from a clock fall.");

   range_flag_a : assert property (
      encRise |=> range_exceeded_flag == $past(coreOverRange))
      else $error("Range flag does not follow the core.");

   lsb_kept_a : assert property (
      encRise && !ditOn |=> sampleData[0] == $past(coreSample[0]))
      else $error("Scrambling altered the low bit.");

   scramble_word_a : assert property (
      encRise && scrOn && !ditOn && !modeNow.twosComplement
      |=> sampleData[MsbPos:1] == ($past(coreSample[MsbPos:1])
          ^ {(SampleWidth-1){$past(coreSample[0])}}))
      else $error("Scrambled word is wrong.");

   plain_word_a : assert property (
      encRise && !scrOn && !ditOn && !modeNow.twosComplement
      |=> sampleData == $past(coreSample))
      else $error("Unscrambled word is altered.");

   twos_msb_a : assert property (
      encRise && !scrOn && !ditOn && modeNow.twosComplement
      |=> sampleData[MsbPos] == !$past(coreSample[MsbPos]))
      else $error("Two's complement MSB not inverted.");

   mode_stab_a : assert property (
      ##1 stabilizerEnable == $past(modeSync_r[0] ^ modeSync_r[1]))
      else $error("Stabilizer enable does not follow mode.");

   dither_sub_a : assert property (
      encRise && ditOn && !scrOn && !modeNow.twosComplement
      |=> sampleData == $past(coreSample) - $past(ditherValue))
      else $error("Dither value not subtracted.");

endmodule

// ==== verilog/aof_lfsr.sv ====
// Long-sequence pseudo-random generator that feeds the dither path.
`timescale 1ns/100ps
module aof_lfsr
   import aof_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 advance,
   output logic      [SampleWidth-1:0] value
);

   logic [LfsrWidth-1:0] state_r;
   logic [LfsrWidth-1:0] state_nxt;

   // A 23-bit maximal sequence; it steps once per sample when asked.
   always_comb
   begin
      state_nxt = state_r;
      if (advance)
      begin
         state_nxt = {state_r[LfsrWidth-2:0],
                      state_r[LfsrWidth-1] ^ state_r[17]};
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= LfsrSeed;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Only a small dither value is used so the offset stays modest.
   assign value = {7'h00, state_r[6:0]};

endmodule
